// ===== ide_port_pkg.sv
// Shared constants for the parallel disk port: timing counts and field widths
`default_nettype none
package ide_port_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // PIO minimum figures, modes 0..4, nanoseconds
    localparam int PIO_CYCLE_NS [0:4] = '{600, 383, 240, 180, 120};
    localparam int PIO_ACTIVE_NS [0:4] = '{165, 125, 100, 80, 70};
    localparam int PIO_ACTIVE8_NS [0:4] = '{290, 290, 290, 80, 70};
    localparam int PIO_RECOVERY_MIN_NS [0:4] = '{0, 0, 0, 70, 25};
    localparam int IORDY_SAMPLE_DELAY_NS = 35;
    localparam int READ_DATA_BEFORE_READY_NS = 0;
    // Multiword DMA minimum figures, modes 0..2
    localparam int DMA_CYCLE_NS [0:2] = '{480, 150, 120};
    localparam int DMA_ACTIVE_NS [0:2] = '{215, 80, 70};
    localparam int DMA_READ_NEGATED_MIN_NS [0:2] = '{50, 50, 25};
    localparam int DMA_WRITE_NEGATED_MIN_NS [0:2] = '{215, 50, 25};
    // Ultra DMA strobe half period per mode 0..4, nanoseconds
    localparam int UDMA_HALF_NS [0:4] = '{120, 80, 60, 45, 30};
    // Least times round up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int IORDY_SAMPLE_CYC = ns_to_cyc(IORDY_SAMPLE_DELAY_NS);
    localparam int READ_DATA_BEFORE_READY_CYC = ns_to_cyc(READ_DATA_BEFORE_READY_NS);
    // Device initialisation time after reset, cycles
    localparam int INIT_BUSY_CYC = 64;
    // Field widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int CNT_W = 8;
    localparam logic [15:0] CRC_SEED = 16'h4ABA;
    // Host transfer kinds
    typedef enum logic [1:0] {
        XFER_PIO = 2'b00,
        XFER_MDMA = 2'b01,
        XFER_UDMA = 2'b10
    } xfer_t;
    // Ultra DMA CRC step, polynomial x^16+x^12+x^5+1
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] d);
        logic [15:0] c;
        c = crc;
        for (int i = 15; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// ===== ide_bus_if.sv
// Bus wires joining the host controller end and the device end
`timescale 1ns/10ps
`default_nettype none
interface ide_bus_if;
    logic [1:0] cs_n;          // Chip selects
    logic [2:0] addr;          // Register address
    logic [15:0] host_d;       // Host data drive
    logic host_d_oe_n;         // Host drives data when low
    logic [15:0] dev_d;        // Device data drive
    logic dev_d_oe_n;          // Device drives data when low
    logic iord_n;              // Read strobe
    logic iowr_n;              // Write strobe
    logic iordy;               // Device ready, low inserts wait
    logic iocs16_n;            // 16-bit transfer indication
    logic dmarq;               // Device DMA request
    logic dmack_n;             // Host DMA acknowledge
    logic oe_n;                // Output enable, held low
    logic ready_busy_out;      // Low while device initialises
    logic crc_err;             // Ultra DMA CRC mismatch seen at device
    logic [15:0] host_crc;     // Host CRC sent at burst end
    wire [15:0] d = !host_d_oe_n ? host_d : (!dev_d_oe_n ? dev_d : 16'h0000);
    modport host (output cs_n, addr, host_d, host_d_oe_n, iord_n, iowr_n, dmack_n, oe_n, host_crc,
                  input dev_d, dev_d_oe_n, iordy, iocs16_n, dmarq, ready_busy_out, crc_err, d);
    modport dev (input cs_n, addr, host_d, host_d_oe_n, iord_n, iowr_n, dmack_n, oe_n, host_crc, d,
                 output dev_d, dev_d_oe_n, iordy, iocs16_n, dmarq, ready_busy_out, crc_err);
endinterface
`default_nettype wire

// ===== ide_device_end.sv
// Device end: task file, IORDY waits, DMA request pacing, reset busy
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Host meets PIO cycle, active, recovery minimums
// - Host may stretch either PIO phase
// - Device accepts any legal host timing
// - Host waits while IORDY low at sample
// - Device inserts wait only via IORDY low
// - Read data valid before IORDY reasserts
// - 16-bit indication only in PIO 0-2
// - Chip selects, three-bit address, 16/8-bit data
// - Host meets per-mode DMA minimums
// - Device may drop DMARQ to pause burst
// - Host may pause DMA via acknowledge
// - Ultra DMA to mode 4 with CRC
// - Ultra timing follows host-selected mode
// - Ready/busy low while initialising after reset
// - Any reset clears task-file registers
// - Host holds output-enable low
module ide_device_end #(
    parameter int WAIT_CYC = 4,
    parameter int INIT_CYC = ide_port_pkg::INIT_BUSY_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bus side
    ide_bus_if.dev bus,
    // User side: soft or bus reset request
    input wire logic i_soft_reset,
    // User side: PIO mode and wait request
    input wire logic [2:0] i_pio_mode,
    input wire logic i_want_wait,
    // User side: DMA data source and sink
    input wire logic i_dma_ready,
    input wire logic [15:0] i_dma_rd_data,
    output logic [15:0] o_dma_wr_data,
    output logic o_dma_wr_valid,
    output logic o_dma_rd_taken,
    // User side: task file view and CRC status
    output logic [15:0] o_data_reg,
    output logic [7:0] o_task_reg [1:7],
    output logic o_crc_err
);
    typedef enum logic [1:0] {
        PIO_IDLE = 2'b00,
        PIO_WAIT = 2'b01,
        PIO_HOLD = 2'b10
    } pio_state_t;

    pio_state_t pio_reg;                   // PIO strobe tracker
    logic [7:0] wait_cnt_reg;              // Wait extension counter
    logic [15:0] init_cnt_reg;             // Busy countdown
    logic busy_reg;                        // Initialising flag
    logic [15:0] rd_data_reg;              // Read data driven out
    logic [15:0] crc_reg;                  // Running Ultra DMA CRC
    logic iord_q_reg;                      // Previous strobe levels
    logic iowr_q_reg;
    logic dmack_q_reg;                     // Acknowledge level last cycle
    logic strobe;                          // Either strobe active
    logic sel;                             // A chip select active
    logic rise_rd;                         // Read strobe released
    logic rise_wr;                         // Write strobe released
    logic dma_on;                          // Acknowledged DMA cycle

    assign strobe = !bus.iord_n || !bus.iowr_n;
    assign sel = bus.cs_n != 2'b11;
    assign dma_on = !bus.dmack_n;
    assign rise_rd = bus.iord_n && !iord_q_reg;
    assign rise_wr = bus.iowr_n && !iowr_q_reg;

    // Strobe edge history
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            iord_q_reg <= 1'b1;
            iowr_q_reg <= 1'b1;
            // Idle level, so no false burst end right after reset
            dmack_q_reg <= 1'b1;
        end else begin
            iord_q_reg <= bus.iord_n;
            iowr_q_reg <= bus.iowr_n;
            dmack_q_reg <= bus.dmack_n;
        end
    end

    // Busy countdown after any reset; soft reset restarts it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            init_cnt_reg <= 16'h0000;
            busy_reg <= 1'b1;
        end else if (i_soft_reset) begin
            init_cnt_reg <= 16'h0000;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            init_cnt_reg <= init_cnt_reg + 16'h0001;
            busy_reg <= (init_cnt_reg < 16'(INIT_CYC - 1));
        end
    end
    assign bus.ready_busy_out = !busy_reg;

    // PIO wait tracking: IORDY drops at strobe start, only when asked
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pio_reg <= PIO_IDLE;
            wait_cnt_reg <= 8'h00;
        end else begin
            case (pio_reg)
                PIO_IDLE: begin
                    // Any active length is fine; state follows the strobe only
                    if (strobe && sel && !dma_on) begin
                        pio_reg <= i_want_wait ? PIO_WAIT : PIO_HOLD;
                        wait_cnt_reg <= 8'h00;
                    end
                end
                PIO_WAIT: begin
                    // Wait length fixed so reassertion follows data setup
                    wait_cnt_reg <= wait_cnt_reg + 8'h01;
                    if (wait_cnt_reg >= 8'(WAIT_CYC + ide_port_pkg::READ_DATA_BEFORE_READY_CYC)) begin
                        pio_reg <= PIO_HOLD;
                    end
                end
                PIO_HOLD: begin
                    if (!strobe) begin
                        pio_reg <= PIO_IDLE;
                    end
                end
                default: pio_reg <= PIO_IDLE;
            endcase
        end
    end
    // IORDY low only while waiting; never pulsed otherwise
    assign bus.iordy = (pio_reg != PIO_WAIT);

    // 16-bit indication only in low PIO modes, else released
    assign bus.iocs16_n = !(sel && i_pio_mode <= 3'h2 && bus.addr == 3'h0);

    // Task file: data word plus seven byte registers, cleared by any reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_data_reg <= 16'h0000;
            for (int i = 1; i < 8; i++) begin
                o_task_reg[i] <= 8'h00;
            end
        end else if (i_soft_reset) begin
            o_data_reg <= 16'h0000;
            for (int i = 1; i < 8; i++) begin
                o_task_reg[i] <= 8'h00;
            end
        end else if (rise_wr && sel && !dma_on) begin
            // Full word at address 0, low byte lane elsewhere
            if (bus.addr == 3'h0) begin
                o_data_reg <= bus.d;
            end else begin
                o_task_reg[bus.addr] <= bus.d[7:0];
            end
        end
    end

    // Read data captured at strobe start and held through the wait
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_data_reg <= 16'h0000;
        end else if (dma_on) begin
            rd_data_reg <= i_dma_rd_data;
        end else if (!bus.iord_n && pio_reg == PIO_IDLE) begin
            rd_data_reg <= (bus.addr == 3'h0) ? o_data_reg : {8'h00, o_task_reg[bus.addr]};
        end
    end
    assign bus.dev_d = rd_data_reg;
    assign bus.dev_d_oe_n = !(!bus.iord_n && (sel || dma_on));

    // DMA request drops when the local side cannot keep up
    assign bus.dmarq = i_dma_ready && !busy_reg;
    // Host pausing by acknowledge simply stops edges; nothing to undo
    assign o_dma_rd_taken = dma_on && rise_rd;

    // DMA write data and CRC over every burst word
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dma_wr_data <= 16'h0000;
            o_dma_wr_valid <= 1'b0;
            crc_reg <= ide_port_pkg::CRC_SEED;
            o_crc_err <= 1'b0;
        end else begin
            // Words follow the host strobes, so any Ultra mode spacing works
            o_dma_wr_valid <= dma_on && rise_wr;
            if (dma_on && rise_wr) begin
                o_dma_wr_data <= bus.d;
                crc_reg <= ide_port_pkg::crc_step(crc_reg, bus.d);
            end else if (dma_on && rise_rd) begin
                crc_reg <= ide_port_pkg::crc_step(crc_reg, rd_data_reg);
            end else if (bus.dmack_n && !dmack_q_reg) begin
                // Burst end: compare against host CRC, set wins over nothing
                o_crc_err <= o_crc_err || (crc_reg != bus.host_crc);
                crc_reg <= ide_port_pkg::CRC_SEED;
            end
        end
    end
    assign bus.crc_err = o_crc_err;
endmodule
`default_nettype wire

// ===== ide_host_end.sv
// Host end: mode-selected strobe timing, IORDY waits, DMA handshake
`timescale 1ns/10ps
`default_nettype none
module ide_host_end (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bus side
    ide_bus_if.host bus,
    // User side request
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [1:0] i_cs_n,
    input wire logic [2:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_kind,
    input wire logic [2:0] i_mode,
    input wire logic i_dma_pause,
    // User side answer
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic o_wide
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_ACT = 2'b01,
        H_REC = 2'b10
    } host_state_t;

    host_state_t st_reg;                   // Cycle phase
    logic [7:0] cnt_reg;                   // Phase counter
    logic [7:0] total_reg;                 // Whole cycle counter
    logic write_reg;                       // Cycle direction
    logic dma_reg;                         // Cycle is DMA
    logic [15:0] crc_reg;                  // Burst CRC
    logic [7:0] act_cyc, rec_cyc, cyc_cyc; // Counts for this mode
    logic ok_to_go;

    // Counts from nanosecond minimums, rounded up
    always_comb begin
        int m;
        m = 32'(i_mode);
        act_cyc = 8'h01;
        rec_cyc = 8'h01;
        cyc_cyc = 8'h01;
        if (i_kind == ide_port_pkg::XFER_PIO) begin
            if (m > 4) m = 4;
            act_cyc = 8'(ide_port_pkg::ns_to_cyc(ide_port_pkg::PIO_ACTIVE8_NS[m]));
            rec_cyc = 8'(ide_port_pkg::ns_to_cyc(ide_port_pkg::PIO_RECOVERY_MIN_NS[m]));
            cyc_cyc = 8'(ide_port_pkg::ns_to_cyc(ide_port_pkg::PIO_CYCLE_NS[m]));
        end else if (i_kind == ide_port_pkg::XFER_MDMA) begin
            if (m > 2) m = 2;
            act_cyc = 8'(ide_port_pkg::ns_to_cyc(ide_port_pkg::DMA_ACTIVE_NS[m]));
            rec_cyc = 8'(ide_port_pkg::ns_to_cyc(i_write ? ide_port_pkg::DMA_WRITE_NEGATED_MIN_NS[m]
                                                         : ide_port_pkg::DMA_READ_NEGATED_MIN_NS[m]));
            cyc_cyc = 8'(ide_port_pkg::ns_to_cyc(ide_port_pkg::DMA_CYCLE_NS[m]));
        end else begin
            if (m > 4) m = 4;
            act_cyc = 8'(ide_port_pkg::ns_to_cyc(ide_port_pkg::UDMA_HALF_NS[m]));
            rec_cyc = act_cyc;
            cyc_cyc = 8'(2 * ide_port_pkg::ns_to_cyc(ide_port_pkg::UDMA_HALF_NS[m]));
        end
    end

    // No operation while device is busy; DMA needs request
    assign ok_to_go = bus.ready_busy_out && (i_kind == ide_port_pkg::XFER_PIO || bus.dmarq);
    assign o_busy = (st_reg != H_IDLE) || !bus.ready_busy_out;

    // Cycle sequencer
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= H_IDLE;
            cnt_reg <= 8'h00;
            total_reg <= 8'h00;
            write_reg <= 1'b0;
            dma_reg <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
            o_wide <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (st_reg)
                H_IDLE: begin
                    if (i_req && ok_to_go && !i_dma_pause) begin
                        st_reg <= H_ACT;
                        cnt_reg <= 8'h01;
                        total_reg <= 8'h01;
                        write_reg <= i_write;
                        dma_reg <= (i_kind != ide_port_pkg::XFER_PIO);
                    end
                end
                H_ACT: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    total_reg <= total_reg + 8'h01;
                    if (cnt_reg == 8'(ide_port_pkg::IORDY_SAMPLE_CYC)) begin
                        o_wide <= !bus.iocs16_n && i_mode <= 3'h2;
                    end
                    // Hold active until minimum met and, for PIO only, IORDY high
                    if (cnt_reg >= act_cyc && (dma_reg || bus.iordy)) begin
                        st_reg <= H_REC;
                        cnt_reg <= 8'h01;
                        if (!write_reg) begin
                            o_rdata <= bus.d;
                        end
                    end
                end
                H_REC: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    total_reg <= total_reg + 8'h01;
                    // Recovery stretched until whole cycle minimum met
                    if (cnt_reg >= rec_cyc && total_reg >= cyc_cyc) begin
                        st_reg <= H_IDLE;
                        o_done <= 1'b1;
                    end
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end

    // Running CRC of words moved in a DMA burst
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            crc_reg <= ide_port_pkg::CRC_SEED;
        end else if (st_reg == H_ACT && dma_reg && cnt_reg >= act_cyc) begin
            crc_reg <= ide_port_pkg::crc_step(crc_reg, bus.d);
        end else if (bus.dmack_n) begin
            // Reseed once acknowledge is released; device compares on that edge
            crc_reg <= ide_port_pkg::CRC_SEED;
        end
    end

    assign bus.cs_n = (st_reg != H_IDLE && !dma_reg) ? i_cs_n : 2'b11;
    assign bus.addr = i_addr;
    assign bus.host_d = i_wdata;
    assign bus.host_d_oe_n = !(st_reg != H_IDLE && write_reg);
    assign bus.iord_n = !(st_reg == H_ACT && !write_reg);
    assign bus.iowr_n = !(st_reg == H_ACT && write_reg);
    // Acknowledge released on host pause or between bursts
    assign bus.dmack_n = !(dma_reg && st_reg != H_IDLE && !i_dma_pause);
    assign bus.oe_n = 1'b0;
    assign bus.host_crc = crc_reg;
endmodule
`default_nettype wire

// ===== ide_port_props.sv
// Concurrent checks on the bus joining host end and device end
`timescale 1ns/10ps
`default_nettype none
module ide_port_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bus signals under watch
    input wire logic [2:0] addr,
    input wire logic iord_n,
    input wire logic iowr_n,
    input wire logic iordy,
    input wire logic iocs16_n,
    input wire logic dmack_n,
    input wire logic oe_n,
    input wire logic dev_d_oe_n,
    input wire logic ready_busy_out
);
    // Shortest PIO cycle of any mode, clocks
    localparam int PIO_GAP_MIN = 12;
    // Longest device wait tolerated, clocks
    localparam int WAIT_MAX = 20;
    logic strobe_prev_reg; // Both strobes idle last cycle
    logic [7:0] gap_reg; // Clocks since last PIO start
    logic pio_start; // PIO strobe starts now
    assign pio_start = strobe_prev_reg && !(iord_n && iowr_n) && dmack_n;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Strobe history for start detection
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strobe_prev_reg <= 1'b1;
        end else begin
            strobe_prev_reg <= iord_n && iowr_n;
        end
    end
    // Saturates so a long idle never wraps into a false short gap
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap_reg <= 8'hFF;
        end else if (pio_start) begin
            gap_reg <= 8'h01;
        end else if (gap_reg != 8'hFF) begin
            gap_reg <= gap_reg + 8'h01;
        end
    end
    // Start of a PIO strobe
    sequence s_pio_start;
        pio_start;
    endsequence
    // PIO strobe held while the device holds its wait
    sequence s_pio_wait;
        !(iord_n && iowr_n) && !iordy && dmack_n;
    endsequence
    a_oe_held_low: assert property (oe_n == 1'b0)
        else $error("output enable not low");
    a_busy_after_reset: assert property ($rose(i_reset_n) |-> !ready_busy_out [*8])
        else $error("ready left low too early");
    a_no_start_busy: assert property (s_pio_start |-> ready_busy_out)
        else $error("strobe while device busy");
    a_pio_active_min: assert property (s_pio_start |-> !(iord_n && iowr_n) [*7])
        else $error("strobe active too short");
    a_pio_cycle_min: assert property (s_pio_start |-> gap_reg >= PIO_GAP_MIN)
        else $error("pio cycle too short");
    a_wait_holds_strobe: assert property (s_pio_wait |=> !(iord_n && iowr_n))
        else $error("strobe released during wait");
    a_wait_bounded: assert property ($fell(iordy) && dmack_n |-> ##[1:WAIT_MAX] iordy)
        else $error("wait not released");
    a_data_before_ready: assert property ($rose(iordy) && !iord_n && dmack_n |-> $past(dev_d_oe_n) == 1'b0)
        else $error("read data late for ready");
    a_wide_data_only: assert property (!iocs16_n |-> addr == 3'h0)
        else $error("wide indication off data register");
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench joining host end and device end
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct {logic [2:0] mode; logic [2:0] a; logic [15:0] d; logic wt;} row_t;
    logic i_clk, i_reset_n;
    // Host user side
    logic h_req, h_write, h_pause, h_busy, h_done, wide;
    logic [1:0] h_cs_n, h_kind;
    logic [2:0] h_addr, h_mode;
    logic [15:0] h_wdata, rdata;
    // Device user side
    logic soft_reset, want_wait, dma_ready, wr_valid, rd_taken, crc_err;
    logic [2:0] pio_mode;
    logic [15:0] dma_rd_data, wr_data, data_reg, last_wr;
    logic [7:0] task_reg [1:7];
    int errors = 0, cmp_count = 0, taken_cnt = 0, n;
    // Mixed modes, waits and addresses
    row_t rows [8] = '{'{3'd0, 3'h0, 16'h1234, 1'b0}, '{3'd1, 3'h2, 16'h0011, 1'b1},
        '{3'd2, 3'h3, 16'h0022, 1'b0}, '{3'd3, 3'h4, 16'h0033, 1'b1}, '{3'd4, 3'h5, 16'h0044, 1'b0},
        '{3'd3, 3'h0, 16'hBEEF, 1'b1}, '{3'd4, 3'h6, 16'h0066, 1'b1}, '{3'd2, 3'h7, 16'h0077, 1'b1}};
    ide_bus_if bus();
    ide_host_end i_ide_host_end (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus), .i_req(h_req),
        .i_write(h_write), .i_cs_n(h_cs_n), .i_addr(h_addr), .i_wdata(h_wdata), .i_kind(h_kind),
        .i_mode(h_mode), .i_dma_pause(h_pause), .o_busy(h_busy), .o_done(h_done), .o_rdata(rdata),
        .o_wide(wide));
    ide_device_end #(.WAIT_CYC(4), .INIT_CYC(64)) i_ide_device_end (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .bus(bus), .i_soft_reset(soft_reset), .i_pio_mode(pio_mode), .i_want_wait(want_wait),
        .i_dma_ready(dma_ready), .i_dma_rd_data(dma_rd_data), .o_dma_wr_data(wr_data),
        .o_dma_wr_valid(wr_valid), .o_dma_rd_taken(rd_taken), .o_data_reg(data_reg),
        .o_task_reg(task_reg), .o_crc_err(crc_err));
    ide_port_props i_ide_port_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .addr(bus.addr),
        .iord_n(bus.iord_n), .iowr_n(bus.iowr_n), .iordy(bus.iordy), .iocs16_n(bus.iocs16_n),
        .dmack_n(bus.dmack_n), .oe_n(bus.oe_n), .dev_d_oe_n(bus.dev_d_oe_n),
        .ready_busy_out(bus.ready_busy_out));
    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Last DMA word delivered, and read words taken
    always @(negedge i_clk) begin
        if (wr_valid === 1'b1) last_wr <= wr_data;
        if (rd_taken === 1'b1) taken_cnt++;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // One host transfer, entered at a falling edge; n gives its length in clocks
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [15:0] wd, input logic [1:0] k,
                        input logic [2:0] m, output int n);
        n = 0;
        h_write = wr;
        h_addr = a;
        h_wdata = wd;
        h_kind = k;
        h_mode = m;
        h_req = 1'b1;
        while (h_done !== 1'b1 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        chk(h_done, 1'b1, "transfer done");
        h_req = 1'b0;
        @(negedge i_clk);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected thousand or so clocks
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        end_of_test();
    end
    initial begin
        {i_reset_n, h_req, h_write, h_pause, h_kind, h_addr, h_mode, h_wdata} = '0;
        {soft_reset, want_wait, dma_ready, pio_mode, dma_rd_data} = '0;
        h_cs_n = 2'b10;
        repeat (20) @(negedge i_clk);
        i_reset_n = 1'b1;
        for (int a = 1; a < 8; a++) chk({8'h00, task_reg[a]}, 16'h0000, "task reg after reset");
        chk(bus.ready_busy_out, 1'b0, "busy after reset");
        chk(bus.oe_n, 1'b0, "output enable");
        n = 0;
        while (bus.ready_busy_out !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        chk(n >= 60 && n < 200, 1'b1, "busy span");
        // Table of PIO writes and read-backs
        foreach (rows[i]) begin
            pio_mode = rows[i].mode;
            want_wait = rows[i].wt;
            xfer(1'b1, rows[i].a, rows[i].d, 2'd0, rows[i].mode, n);
            if (rows[i].a == 3'h0) chk(data_reg, rows[i].d, "data reg");
            else chk({8'h00, task_reg[rows[i].a]}, {8'h00, rows[i].d[7:0]}, "task reg");
            xfer(1'b0, rows[i].a, 16'h0000, 2'd0, rows[i].mode, n);
            if (rows[i].a == 3'h0) chk(rdata, rows[i].d, "data read");
            else if (rows[i].a != 3'h1 && rows[i].a != 3'h7) chk({8'h00, rdata[7:0]}, {8'h00, rows[i].d[7:0]}, "reg read");
            chk(wide, rows[i].a == 3'h0 && rows[i].mode <= 3'd2, "wide flag");
        end
        // Every DMA and Ultra DMA mode, one read and one write each
        want_wait = 1'b0;
        dma_ready = 1'b1;
        dma_rd_data = 16'hA5C3;
        for (int m = 0; m < 5; m++) begin
            for (int k = 1; k < 3; k++) begin
                if (k == 1 && m > 2) continue;
                xfer(1'b0, 3'h0, 16'h0000, k[1:0], m[2:0], n);
                chk(rdata, 16'hA5C3, "dma read");
                xfer(1'b1, 3'h0, 16'h3C5A ^ m[15:0], k[1:0], m[2:0], n);
                chk(last_wr, 16'h3C5A ^ m[15:0], "dma write");
            end
        end
        chk(taken_cnt[15:0], 16'h0008, "read words taken");
        // Pause the host; acknowledge is already released in H_IDLE, so the burst check is done
        h_pause = 1'b1;
        repeat (10) @(negedge i_clk);
        chk(crc_err, 1'b0, "burst check");
        // Device pauses its request, then host pauses its acknowledge
        dma_ready = 1'b0;
        h_pause = 1'b0;
        fork
            xfer(1'b0, 3'h0, 16'h0000, 2'd1, 3'd2, n);
            begin
                repeat (30) @(negedge i_clk);
                dma_ready = 1'b1;
            end
        join
        chk(n >= 28, 1'b1, "device pause");
        h_pause = 1'b1;
        fork
            xfer(1'b1, 3'h0, 16'h0F0F, 2'd1, 3'd2, n);
            begin
                repeat (30) @(negedge i_clk);
                h_pause = 1'b0;
            end
        join
        chk(n >= 28, 1'b1, "host pause");
        chk(last_wr, 16'h0F0F, "paused write");
        chk(crc_err, 1'b0, "paused burst check");
        // Soft reset clears task file and blocks the host while busy
        pio_mode = 3'd4;
        xfer(1'b1, 3'h3, 16'h00A7, 2'd0, 3'd4, n);
        soft_reset = 1'b1;
        @(negedge i_clk);
        soft_reset = 1'b0;
        chk({8'h00, task_reg[3]}, 16'h0000, "soft reset clear");
        chk(bus.ready_busy_out, 1'b0, "busy after soft reset");
        chk(h_busy, 1'b1, "host refuses while busy");
        xfer(1'b1, 3'h4, 16'h005C, 2'd0, 3'd4, n);
        chk(n >= 55, 1'b1, "held while busy");
        chk({8'h00, task_reg[4]}, 16'h005C, "write after busy");
        end_of_test();
    end
endmodule
`default_nettype wire
